// ---- rtl/sbf_regs.svh ----
// Register offsets, field positions, reset values and timing counts
// Operation
// - Infrared receive 2 wired to line 38 input
// - Line 38 selected means infrared sees ball
// - Bits 14 and 22 set give low-pin-count bus
// - Bits 14 and 22 clear give general lines
// - Parallel port only when 23, 27, strap clear
// - Bit 23 alone gives flat-panel data lines
// - Bit 27 or strap gives bus monitor outputs
// - Paper-end ball pull chosen by software
// - Line 6 ball decoded from bits 18, 8
// - Serial 2 transmit ball doubles as clock strap
`ifndef SBF_REGS_SVH
`define SBF_REGS_SVH

// ==========================================================
// Register offsets on the plain port
`define SBF_OFS_PIN_MUX 8'h00
`define SBF_OFS_PE_PULL 8'h04
`define SBF_OFS_STATUS 8'h08
`define SBF_PIN_MUX_RST 32'h0000_0000
`define SBF_PE_PULL_RST 2'h0
`define SBF_RD_ZERO 32'h0000_0000

// ==========================================================
// Pin mux configuration bit positions
`define SBF_BIT_LPC_A 14
`define SBF_BIT_LPC_B 22
`define SBF_BIT_FLAT 23
`define SBF_BIT_MON 27
`define SBF_BIT_GP6_HI 18
`define SBF_BIT_GP6_LO 8

// ==========================================================
// Paper-end pull control fields
`define SBF_PE_EN 0
`define SBF_PE_UP 1

// ==========================================================
// Status register fields
`define SBF_ST_PAR_LO 0
`define SBF_ST_PAR_HI 2
`define SBF_ST_LPC 3
`define SBF_ST_GP6_LO 4
`define SBF_ST_GP6_HI 7
`define SBF_ST_CLKSEL 8
`define SBF_ST_MONSTRAP 9
`define SBF_ST_DONE 10

// ==========================================================
// Ball index of line 38 inside the 32..39 group
`define SBF_GP38_IDX 6

// ==========================================================
// Strap settle time and clock period
`define SBF_STRAP_SETTLE_NS 40
`define SBF_CLK_PERIOD_NS 4
`define SBF_STRAP_SETTLE_CYC \
  ((`SBF_STRAP_SETTLE_NS + `SBF_CLK_PERIOD_NS - 1) / `SBF_CLK_PERIOD_NS)

`endif

// ---- rtl/sbf_pkg.sv ----
// Types shared by the shared ball function select design
package sbf_pkg;

  // ========================================================
  // Function of the parallel, flat-panel, monitor ball group
  typedef enum logic [2:0]
  {
    SBF_PAR_PORT = 3'b001,
    SBF_PAR_FLAT = 3'b010,
    SBF_PAR_MON = 3'b100
  } sbf_par_mode_t;

  // ========================================================
  // Function of the line 6 ball
  typedef enum logic [3:0]
  {
    SBF_GP6_GEN = 4'b0001,
    SBF_GP6_SER2 = 4'b0010,
    SBF_GP6_STOR = 4'b0100,
    SBF_GP6_TEST = 4'b1000
  } sbf_gp6_sel_t;

  // ========================================================
  // Strap capture sequence
  typedef enum logic [2:0]
  {
    SBF_STR_IDLE = 3'b001,
    SBF_STR_SETTLE = 3'b010,
    SBF_STR_DONE = 3'b100
  } sbf_strap_st_t;

  // ========================================================
  // Strap capture state
  typedef struct packed
  {
    sbf_strap_st_t st;
    logic [7:0] cnt;
    logic [1:0] val;
    logic done;
  } sbf_strap_state_t;

  // ========================================================
  // Top state: configuration, read data and every ball output
  typedef struct packed
  {
    logic [31:0] pinMux;
    logic [1:0] peCfg;
    logic [31:0] rdata;
    sbf_par_mode_t parMode;
    sbf_gp6_sel_t gp6Sel;
    logic lpcSel;
    logic [3:0] parBallOut;
    logic [3:0] parBallOe;
    logic [3:0] parIn;
    logic peFromBall;
    logic pePullUp;
    logic pePullDn;
    logic [7:0] lpcBallOut;
    logic [7:0] lpcBallOe;
    logic [7:0] gpIn;
    logic [7:0] lpcIn;
    logic infrared_rx_2;
    logic gp6BallOut;
    logic gp6BallOe;
    logic gp6In;
    logic ser2BallOut;
    logic ser2BallOe;
  } sbf_top_state_t;

endpackage

// ---- rtl/sbf_sel3.sv ----
// One ball of the parallel, flat-panel, monitor group
`timescale 1ns/1ps
module sbf_sel3
(
  input sbf_pkg::sbf_par_mode_t mode,
  input wire logic parOut,
  input wire logic parOe,
  input wire logic flatOut,
  input wire logic monOut,
  output logic ballOut,
  output logic ballOe
);

  // Pick the driver of the ball from the group mode
  always_comb
  begin
    ballOut = 1'b0;
    ballOe = 1'b0;
    case (mode)
      sbf_pkg::SBF_PAR_PORT:
      begin
        ballOut = parOut;
        ballOe = parOe;
      end
      sbf_pkg::SBF_PAR_FLAT:
      begin
        ballOut = flatOut;
        ballOe = 1'b1;
      end
      sbf_pkg::SBF_PAR_MON:
      begin
        ballOut = monOut;
        ballOe = 1'b1;
      end
      default:
      begin
        ballOut = 1'b0;
        ballOe = 1'b0;
      end
    endcase
  end

endmodule

// ---- rtl/sbf_strap_capture.sv ----
// Strap sampler: waits for the pulls to settle, then holds the levels
`timescale 1ns/1ps
`include "sbf_regs.svh"
module sbf_strap_capture
#(
  parameter int WIDTH = 2,
  parameter int SETTLE = `SBF_STRAP_SETTLE_CYC
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [1:0] strapIn,
  output logic [1:0] strapVal,
  output logic strapDone
);

  sbf_pkg::sbf_strap_state_t s_ff;
  sbf_pkg::sbf_strap_state_t nxt_s;

  // Count the settle time, sample once, then hold
  always_comb
  begin
    nxt_s = s_ff;
    case (s_ff.st)
      sbf_pkg::SBF_STR_IDLE:
      begin
        nxt_s.st = sbf_pkg::SBF_STR_SETTLE;
        nxt_s.cnt = 8'h00;
      end
      sbf_pkg::SBF_STR_SETTLE:
      begin
        nxt_s.cnt = s_ff.cnt + 8'h01;
        if (s_ff.cnt == 8'(SETTLE - 1))
        begin
          nxt_s.st = sbf_pkg::SBF_STR_DONE;
          nxt_s.val = strapIn;
          nxt_s.done = 1'b1;
        end
      end
      sbf_pkg::SBF_STR_DONE:
      begin
        nxt_s.st = sbf_pkg::SBF_STR_DONE;
      end
      default:
      begin
        nxt_s.st = sbf_pkg::SBF_STR_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_ff <= '{st: sbf_pkg::SBF_STR_IDLE, cnt: 8'h00, val: 2'h0,
                done: 1'b0};
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign strapVal = s_ff.val;
  assign strapDone = s_ff.done;

endmodule

// ---- rtl/sbf_ball_mux.sv ----
// Top of the shared ball function select block
`timescale 1ns/1ps
`include "sbf_regs.svh"
module sbf_ball_mux
(
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Parallel port unit, per ball: data, error, paper-end, strobe
  input wire logic [3:0] parOut,
  input wire logic [3:0] parOe,
  output logic [3:0] parIn,
  // Flat-panel data lines and fast bus monitor lines for the group
  input wire logic [3:0] flatDataLine,
  input wire logic [3:0] monitorLine,
  // Balls of the shared group
  input wire logic [3:0] parBallIn,
  output logic [3:0] parBallOut,
  output logic [3:0] parBallOe,
  output logic pePullUp,
  output logic pePullDn,
  // General lines 32..39 and low-pin-count bus unit, per ball
  input wire logic [7:0] gpOut,
  input wire logic [7:0] gpOe,
  output logic [7:0] gpIn,
  input wire logic [7:0] lpcOut,
  input wire logic [7:0] lpcOe,
  output logic [7:0] lpcIn,
  output logic infraredRx2,
  input wire logic [7:0] lpcBallIn,
  output logic [7:0] lpcBallOut,
  output logic [7:0] lpcBallOe,
  // Line 6 ball and its four functions
  input wire logic gp6Out,
  input wire logic gp6Oe,
  output logic gp6In,
  input wire logic serial2TermReady,
  input wire logic storage1ReadStrobe,
  input wire logic memoryTestOut5,
  input wire logic gp6BallIn,
  output logic gp6BallOut,
  output logic gp6BallOe,
  // Serial 2 transmit ball and clock-select strap
  input wire logic serial2TxOut,
  input wire logic ser2BallIn,
  output logic ser2BallOut,
  output logic ser2BallOe,
  output logic clockSelectStrap2,
  // Fast bus monitor strap ball
  input wire logic monStrapBallIn,
  output logic fastBusMonitorStrap
);

  sbf_pkg::sbf_top_state_t s_ff;
  sbf_pkg::sbf_top_state_t nxt_s;
  sbf_pkg::sbf_par_mode_t curMode;
  logic [1:0] strapVal;
  logic strapDone;
  logic [3:0] selOut;
  logic [3:0] selOe;
  logic lpcPair;
  logic lpcSplit;

  // ========================================================
  // Decode functions

  // Group mode from the configuration and the monitor strap
  function automatic sbf_pkg::sbf_par_mode_t parModeOf(
    input logic [31:0] pm,
    input logic monStrap
  );
    sbf_pkg::sbf_par_mode_t m;
    m = sbf_pkg::SBF_PAR_PORT;
    // monitor takes group, also over flat
    if (pm[`SBF_BIT_MON] || monStrap)
      m = sbf_pkg::SBF_PAR_MON;
    else if (pm[`SBF_BIT_FLAT])
      m = sbf_pkg::SBF_PAR_FLAT;
    else
      m = sbf_pkg::SBF_PAR_PORT;
    return m;
  endfunction

  // Line 6 ball function from bits 18 and 8
  function automatic sbf_pkg::sbf_gp6_sel_t gp6SelOf(
    input logic [31:0] pm
  );
    sbf_pkg::sbf_gp6_sel_t g;
    g = sbf_pkg::SBF_GP6_GEN;
    case ({pm[`SBF_BIT_GP6_HI], pm[`SBF_BIT_GP6_LO]})
      2'b10: g = sbf_pkg::SBF_GP6_SER2;
      2'b01: g = sbf_pkg::SBF_GP6_STOR;
      2'b11: g = sbf_pkg::SBF_GP6_TEST;
      default: g = sbf_pkg::SBF_GP6_GEN;
    endcase
    return g;
  endfunction

  // ========================================================
  // Strap capture and group drivers

  sbf_strap_capture #(
    .WIDTH(2),
    .SETTLE(`SBF_STRAP_SETTLE_CYC)
  ) u_strap (
    .mclk(mclk),
    .reset(reset),
    .strapIn({monStrapBallIn, ser2BallIn}),
    .strapVal(strapVal),
    .strapDone(strapDone)
  );

  // Parallel port only with flat, monitor and strap all clear
  assign curMode = parModeOf(s_ff.pinMux, strapVal[1]);
  assign lpcPair = s_ff.pinMux[`SBF_BIT_LPC_A] &&
                   s_ff.pinMux[`SBF_BIT_LPC_B];
  assign lpcSplit = s_ff.pinMux[`SBF_BIT_LPC_A] ^
                    s_ff.pinMux[`SBF_BIT_LPC_B];

  // One selector per ball of the shared group
  for (genvar i = 0; i < 4; i++)
  begin : g_sel
    sbf_sel3 u_sel (
      .mode(curMode),
      .parOut(parOut[i]),
      .parOe(parOe[i]),
      .flatOut(flatDataLine[i]),
      .monOut(monitorLine[i]),
      .ballOut(selOut[i]),
      .ballOe(selOe[i])
    );
  end

  // ========================================================
  // Next state

  // Register port, then every ball path
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.rdata = `SBF_RD_ZERO;
    if (regWr)
    begin
      if (regAddr == `SBF_OFS_PIN_MUX)
        nxt_s.pinMux = regWdata;
      else if (regAddr == `SBF_OFS_PE_PULL)
        nxt_s.peCfg = regWdata[1:0];
    end
    if (regRd)
    begin
      if (regAddr == `SBF_OFS_PIN_MUX)
        nxt_s.rdata = s_ff.pinMux;
      else if (regAddr == `SBF_OFS_PE_PULL)
        nxt_s.rdata = {30'h0000_0000, s_ff.peCfg};
      else if (regAddr == `SBF_OFS_STATUS)
      begin
        nxt_s.rdata[`SBF_ST_PAR_HI:`SBF_ST_PAR_LO] = s_ff.parMode;
        nxt_s.rdata[`SBF_ST_LPC] = s_ff.lpcSel;
        nxt_s.rdata[`SBF_ST_GP6_HI:`SBF_ST_GP6_LO] = s_ff.gp6Sel;
        nxt_s.rdata[`SBF_ST_CLKSEL] = strapVal[0];
        nxt_s.rdata[`SBF_ST_MONSTRAP] = strapVal[1];
        nxt_s.rdata[`SBF_ST_DONE] = strapDone;
      end
      else
        nxt_s.rdata = `SBF_RD_ZERO;
    end

    // Shared group: drivers from the selectors, inputs to parallel
    nxt_s.parMode = curMode;
    nxt_s.parBallOut = selOut;
    nxt_s.parBallOe = selOe;
    nxt_s.parIn = (curMode == sbf_pkg::SBF_PAR_PORT) ?
                  parBallIn : 4'h0;
    nxt_s.pePullUp = (curMode == sbf_pkg::SBF_PAR_PORT) &&
                     s_ff.peCfg[`SBF_PE_EN] && s_ff.peCfg[`SBF_PE_UP];
    nxt_s.pePullDn = (curMode == sbf_pkg::SBF_PAR_PORT) &&
                     s_ff.peCfg[`SBF_PE_EN] && !s_ff.peCfg[`SBF_PE_UP];

    // General lines against the low-pin-count bus
    nxt_s.lpcSel = lpcPair;
    if (lpcPair)
    begin
      nxt_s.lpcBallOut = lpcOut;
      nxt_s.lpcBallOe = lpcOe;
      nxt_s.lpcIn = lpcBallIn;
      nxt_s.gpIn = 8'h00;
    end
    else
    begin
      nxt_s.lpcBallOut = gpOut;
      nxt_s.lpcBallOe = gpOe;
      nxt_s.gpIn = lpcBallIn;
      nxt_s.lpcIn = 8'h00;
    end
    nxt_s.infrared_rx_2 = lpcBallIn[`SBF_GP38_IDX];

    nxt_s.gp6Sel = gp6SelOf(s_ff.pinMux);
    nxt_s.gp6In = 1'b0;
    case (nxt_s.gp6Sel)
      sbf_pkg::SBF_GP6_GEN:
      begin
        nxt_s.gp6BallOut = gp6Out;
        nxt_s.gp6BallOe = gp6Oe;
        nxt_s.gp6In = gp6BallIn;
      end
      sbf_pkg::SBF_GP6_SER2:
      begin
        nxt_s.gp6BallOut = serial2TermReady;
        nxt_s.gp6BallOe = 1'b1;
      end
      sbf_pkg::SBF_GP6_STOR:
      begin
        nxt_s.gp6BallOut = storage1ReadStrobe;
        nxt_s.gp6BallOe = 1'b1;
      end
      sbf_pkg::SBF_GP6_TEST:
      begin
        nxt_s.gp6BallOut = memoryTestOut5;
        nxt_s.gp6BallOe = 1'b1;
      end
      default:
      begin
        nxt_s.gp6BallOut = 1'b0;
        nxt_s.gp6BallOe = 1'b0;
      end
    endcase

    nxt_s.ser2BallOut = strapDone ? serial2TxOut : 1'b0;
    nxt_s.ser2BallOe = strapDone;
  end

  // ========================================================
  // State register
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_ff <= '{pinMux: `SBF_PIN_MUX_RST, peCfg: `SBF_PE_PULL_RST,
                rdata: `SBF_RD_ZERO, parMode: sbf_pkg::SBF_PAR_PORT,
                gp6Sel: sbf_pkg::SBF_GP6_GEN, default: '0};
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // ========================================================
  // Outputs straight from the state register, straps from the strap capture
  assign regRdata = s_ff.rdata;
  assign parIn = s_ff.parIn;
  assign parBallOut = s_ff.parBallOut;
  assign parBallOe = s_ff.parBallOe;
  assign pePullUp = s_ff.pePullUp;
  assign pePullDn = s_ff.pePullDn;
  assign gpIn = s_ff.gpIn;
  assign lpcIn = s_ff.lpcIn;
  assign infraredRx2 = s_ff.infrared_rx_2;
  assign lpcBallOut = s_ff.lpcBallOut;
  assign lpcBallOe = s_ff.lpcBallOe;
  assign gp6In = s_ff.gp6In;
  assign gp6BallOut = s_ff.gp6BallOut;
  assign gp6BallOe = s_ff.gp6BallOe;
  assign ser2BallOut = s_ff.ser2BallOut;
  assign ser2BallOe = s_ff.ser2BallOe;
  assign clockSelectStrap2 = strapVal[0];
  assign fastBusMonitorStrap = strapVal[1];

  // ========================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_ir_tap_wire: assert property (
    ##1 infraredRx2 == $past(lpcBallIn[`SBF_GP38_IDX]))
    else $error("infrared tap does not follow line 38 ball");

  a_ir_gp_same: assert property (
    !lpcPair |=> infraredRx2 == gpIn[`SBF_GP38_IDX])
    else $error("infrared tap differs from line 38 input");

  a_lpc_bus_route: assert property (
    lpcPair |=> lpcBallOut == $past(lpcOut) &&
                lpcBallOe == $past(lpcOe) && lpcIn == $past(lpcBallIn))
    else $error("low-pin-count bus not routed to balls");

  a_gp_line_route: assert property (
    (!s_ff.pinMux[`SBF_BIT_LPC_A] && !s_ff.pinMux[`SBF_BIT_LPC_B])
    |=> lpcBallOut == $past(gpOut) && gpIn == $past(lpcBallIn))
    else $error("general lines not routed to balls");

  a_par_port_route: assert property (
    (!s_ff.pinMux[`SBF_BIT_FLAT] && !s_ff.pinMux[`SBF_BIT_MON] &&
     !strapVal[1]) |=> parBallOut == $past(parOut) &&
                       parBallOe == $past(parOe) &&
                       parIn == $past(parBallIn))
    else $error("parallel port not on shared group");

  a_flat_route: assert property (
    (s_ff.pinMux[`SBF_BIT_FLAT] && !s_ff.pinMux[`SBF_BIT_MON] &&
     !strapVal[1]) |=> parBallOut == $past(flatDataLine) &&
                       parBallOe == 4'hF && parIn == 4'h0)
    else $error("flat-panel lines not on shared group");

  a_mon_route: assert property (
    (!s_ff.pinMux[`SBF_BIT_FLAT] &&
     (s_ff.pinMux[`SBF_BIT_MON] || strapVal[1]))
    |=> parBallOut == $past(monitorLine) && parBallOe == 4'hF)
    else $error("bus monitor lines not on shared group");

  a_pe_pull_sel: assert property (
    ##1 (pePullUp || pePullDn) |->
      $past(curMode) == sbf_pkg::SBF_PAR_PORT &&
      $past(s_ff.peCfg[`SBF_PE_EN]) &&
      pePullUp == $past(s_ff.peCfg[`SBF_PE_UP]) && !(pePullUp && pePullDn))
    else $error("paper-end pull wrong");

  a_gp6_decode: assert property (
    (s_ff.pinMux[`SBF_BIT_GP6_HI] && s_ff.pinMux[`SBF_BIT_GP6_LO])
    |=> gp6BallOut == $past(memoryTestOut5) && gp6BallOe && !gp6In)
    else $error("line 6 ball not carrying test output");

  a_gp6_ser2: assert property (
    (s_ff.pinMux[`SBF_BIT_GP6_HI] && !s_ff.pinMux[`SBF_BIT_GP6_LO])
    |=> gp6BallOut == $past(serial2TermReady) && gp6BallOe)
    else $error("line 6 ball not carrying terminal ready");

  a_strap_quiet: assert property (
    !strapDone |=> !ser2BallOe)
    else $error("serial 2 ball driven before strap taken");

  a_strap_hold: assert property (
    strapDone |=> strapDone && $stable(clockSelectStrap2))
    else $error("clock-select strap changed after capture");

  a_split_gp: assert property (
    lpcSplit |=> lpcBallOut == $past(gpOut) && !lpcIn[0] &&
                 lpcBallOe == $past(gpOe))
    else $error("split setting did not keep general lines");

  // Read data one cycle after the strobe
  a_reg_read: assert property (
    (regRd && regAddr == `SBF_OFS_PIN_MUX && !regWr)
    |=> regRdata == $past(s_ff.pinMux))
    else $error("configuration read data wrong");

  c_lpc_mode: cover property (lpcPair ##1 lpcBallOe != 8'h00);
  c_flat_mode: cover property (curMode == sbf_pkg::SBF_PAR_FLAT);
  c_mon_strap: cover property (strapVal[1] && strapDone);
  c_gp6_test: cover property (s_ff.gp6Sel == sbf_pkg::SBF_GP6_TEST);

endmodule

// ---- dv/sbf_board_model.sv ----
// Board model: peripheral drive and pulls on the shared balls
`timescale 1ns/1ps
module sbf_board_model
(
  input wire logic mclk,
  input wire logic [3:0] parBallOut,
  input wire logic [3:0] parBallOe,
  input wire logic pePullUp,
  input wire logic pePullDn,
  input wire logic [3:0] parDrv,
  input wire logic [3:0] parDrvEn,
  output logic [3:0] parBallIn,
  input wire logic [7:0] lpcBallOut,
  input wire logic [7:0] lpcBallOe,
  input wire logic [7:0] lpcDrv,
  output logic [7:0] lpcBallIn,
  input wire logic gp6BallOut,
  input wire logic gp6BallOe,
  output logic gp6BallIn,
  input wire logic ser2BallOut,
  input wire logic ser2BallOe,
  input wire logic ser2DrvEn,
  output logic ser2BallIn
);
  logic noise = 1'b0;

  // ==========================================================
  // Floating balls
  // Undriven balls of the parallel group with no pull wander every cycle
  always @(posedge mclk)
    noise <= ~noise;

  // ==========================================================
  // Ball levels
  // paper-end pull level
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      parBallIn[i] = parBallOe[i] ? parBallOut[i] :
                     parDrvEn[i] ? parDrv[i] : noise;
    if (!parBallOe[2] && !parDrvEn[2] && (pePullUp ^ pePullDn))
      parBallIn[2] = pePullUp;
  end

  // Board peripheral drives the lines that the device leaves free
  assign lpcBallIn = (lpcBallOe & lpcBallOut) | (~lpcBallOe & lpcDrv);
  // Pull-up on the line 6 ball
  assign gp6BallIn = gp6BallOe ? gp6BallOut : 1'b1;
  assign ser2BallIn = ser2BallOe ? ser2BallOut : ser2DrvEn;
endmodule

// ---- dv/tb_shared_ball_function_select.sv ----
// Self-checking bench for the shared ball function select block
`timescale 1ns/1ps
`include "sbf_regs.svh"
module tb_shared_ball_function_select;
  // ==========================================================
  // Wiring
  logic mclk, reset, regWr, regRd, gp6Out, gp6Oe, serial2TermReady;
  logic storage1ReadStrobe, memoryTestOut5, serial2TxOut, monStrapBallIn;
  logic pePullUp, pePullDn, infraredRx2, gp6In, gp6BallIn, gp6BallOut;
  logic gp6BallOe, ser2BallIn, ser2BallOut, ser2BallOe, clockSelectStrap2;
  logic fastBusMonitorStrap, ser2DrvEn;
  logic [7:0] regAddr, gpOut, gpOe, gpIn, lpcOut, lpcOe, lpcIn, lpcBallIn;
  logic [7:0] lpcBallOut, lpcBallOe, lpcDrv;
  logic [31:0] regWdata, regRdata;
  logic [3:0] parOut, parOe, parIn, flatDataLine, monitorLine, parBallIn;
  logic [3:0] parBallOut, parBallOe, parDrv, parDrvEn;
  int fails = 0;
  int checksDone = 0;

  sbf_ball_mux uut
  (
    .mclk, .reset, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .parOut, .parOe, .parIn, .flatDataLine, .monitorLine, .parBallIn,
    .parBallOut, .parBallOe, .pePullUp, .pePullDn, .gpOut, .gpOe, .gpIn,
    .lpcOut, .lpcOe, .lpcIn, .infraredRx2, .lpcBallIn, .lpcBallOut,
    .lpcBallOe, .gp6Out, .gp6Oe, .gp6In, .serial2TermReady,
    .storage1ReadStrobe, .memoryTestOut5, .gp6BallIn, .gp6BallOut,
    .gp6BallOe, .serial2TxOut, .ser2BallIn, .ser2BallOut, .ser2BallOe,
    .clockSelectStrap2, .monStrapBallIn, .fastBusMonitorStrap
  );

  sbf_board_model board
  (
    .mclk, .parBallOut, .parBallOe, .pePullUp, .pePullDn, .parDrv,
    .parDrvEn, .parBallIn, .lpcBallOut, .lpcBallOe, .lpcDrv, .lpcBallIn,
    .gp6BallOut, .gp6BallOe, .gp6BallIn, .ser2BallOut, .ser2BallOe,
    .ser2DrvEn, .ser2BallIn
  );

  // ==========================================================
  // Clock, watchdog and shared tasks
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Cuts a hang short
  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    end_of_test();
  end

  task automatic end_of_test();
    if (fails == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checksDone++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic settle();
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 chk("regRdata", regRdata, e);
    @(posedge mclk);
    #1 chk("regRdata idle", regRdata, 32'h0000_0000);
  endtask

  // ==========================================================
  // Scenarios
  // Reset with straps set to a level, then capture and release
  task automatic t_strap(input logic hi);
    @(posedge mclk);
    monStrapBallIn <= hi;
    ser2DrvEn <= hi;
    reset <= 1'b1;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("ser2BallOe early", ser2BallOe, 0);
    repeat (20) @(posedge mclk);
    ser2DrvEn <= 1'b0;
    serial2TxOut <= !hi;
    #1 chk("clockSelectStrap2", clockSelectStrap2, hi);
    chk("fastBusMonitorStrap", fastBusMonitorStrap, hi);
    settle();
    chk("ser2 ball", {ser2BallOe, ser2BallOut}, {1'b1, !hi});
    rd(`SBF_OFS_STATUS,
       {21'h0, 1'b1, hi, hi, 5'h02, hi, 1'b0, !hi});
  endtask

  // Group balls under every bit 23 and 27 setting
  task automatic t_group(input logic mon);
    logic [31:0] pm;
    logic [2:0] md;
    for (int i = 0; i < 4; i++)
    begin
      pm = {4'h0, i[1], 3'h0, i[0], 23'h0};
      md = (i[1] | mon) ? 3'h4 : i[0] ? 3'h2 : 3'h1;
      wr(`SBF_OFS_PIN_MUX, pm);
      settle();
      chk("parBallOe", parBallOe, md[0] ? parOe : 4'hf);
      chk("parBallOut", parBallOut & parBallOe, md[0] ? parOut & parOe :
          md[1] ? flatDataLine : monitorLine);
      chk("parIn", parIn, md[0] ? 4'h9 : 4'h0);
      rd(`SBF_OFS_PIN_MUX, pm);
      rd(`SBF_OFS_STATUS, {21'h0, 1'b1, mon, mon, 5'h02, md});
    end
  endtask

  // Paper-end pull up, down and off with the ball left free
  task automatic t_pull();
    logic [1:0] v;
    @(posedge mclk);
    parOe <= 4'h8;
    wr(`SBF_OFS_PIN_MUX, 32'h0000_0000);
    for (int i = 0; i < 3; i++)
    begin
      v = i == 0 ? 2'h3 : i == 1 ? 2'h1 : 2'h0;
      wr(`SBF_OFS_PE_PULL, {30'h0, v});
      settle();
      chk("pePullUp", pePullUp, v == 2'h3);
      chk("pePullDn", pePullDn, v == 2'h1);
      if (v[0])
        chk("paper-end level", parIn[2], v[1]);
      rd(`SBF_OFS_PE_PULL, {30'h0, v});
    end
    wr(`SBF_OFS_PE_PULL, 32'h0000_0003);
    wr(`SBF_OFS_PIN_MUX, 32'h0080_0000);
    settle();
    chk("pePullUp flat", pePullUp, 1'b0);
    @(posedge mclk);
    parOe <= 4'hc;
  endtask

  // General lines 32..39 against the bus for bits 14 and 22
  task automatic t_lpc();
    logic [7:0] oe, out, lvl;
    logic sel;
    for (int i = 0; i < 4; i++)
    begin
      sel = i == 3;
      oe = sel ? lpcOe : gpOe;
      out = sel ? lpcOut : gpOut;
      lvl = (oe & out) | (~oe & lpcDrv);
      wr(`SBF_OFS_PIN_MUX, {9'h0, i[1], 7'h0, i[0], 14'h0});
      settle();
      chk("lpcBallOe", lpcBallOe, oe);
      chk("lpcBallOut", lpcBallOut & oe, out & oe);
      chk("gpIn", gpIn, sel ? 8'h0 : lvl);
      chk("lpcIn", lpcIn, sel ? lvl : 8'h0);
      chk("infraredRx2", infraredRx2, lvl[6]);
      rd(`SBF_OFS_STATUS, {21'h0, 7'h41, sel, 3'h1});
    end
  endtask

  // Line 6 ball through its four functions, two source patterns
  task automatic t_gp6();
    logic ex, eo;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 4; i++)
      begin
        @(posedge mclk);
        serial2TermReady <= !p[0];
        storage1ReadStrobe <= p[0];
        memoryTestOut5 <= !p[0];
        gp6Oe <= p[0];
        wr(`SBF_OFS_PIN_MUX, {13'h0, i[1], 9'h0, i[0], 8'h0});
        settle();
        eo = i == 0 ? p[0] : 1'b1;
        ex = (i < 2) ? p[0] : !p[0];
        chk("gp6BallOe", gp6BallOe, eo);
        chk("gp6BallOut", gp6BallOut & eo, ex);
        chk("gp6In", gp6In, i == 0);
        rd(`SBF_OFS_STATUS,
           {21'h0, 3'h4, 4'h1 << {i[0], i[1]}, 4'h1});
      end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    reset = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    parOut = 4'ha;
    parOe = 4'hc;
    flatDataLine = 4'h5;
    monitorLine = 4'h9;
    gpOut = 8'h5a;
    gpOe = 8'h0f;
    lpcOut = 8'hc3;
    lpcOe = 8'hf0;
    gp6Out = 1'b1;
    gp6Oe = 1'b0;
    serial2TermReady = 1'b0;
    storage1ReadStrobe = 1'b0;
    memoryTestOut5 = 1'b0;
    serial2TxOut = 1'b1;
    monStrapBallIn = 1'b0;
    parDrv = 4'h1;
    parDrvEn = 4'h3;
    lpcDrv = 8'h96;
    ser2DrvEn = 1'b0;
    t_strap(1'b1);
    t_group(1'b1);
    t_strap(1'b0);
    t_group(1'b0);
    t_pull();
    t_lpc();
    t_gp6();
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0000_0000);
    rd(`SBF_OFS_PIN_MUX, 32'h0004_0100);
    end_of_test();
  end
endmodule
